// File: src/awsc_pkg.sv
// package with register map, field layout and timing tables for area wait state control
//
// Contract
// R1 - one 16-bit read/write wait control register, one field per external area; areas 1 and 7 have no field here
// R2 - area 6 field bits 15:13 gives first waits 0,1,2,3,4,6,8,10; wait ignored at 000
// R3 - area 6 burst transfers take 2,2,3,4,4,6,8,10 states; wait honoured always
// R4 - area 5 field bits 12:10 encoded like area 6, first waits and burst pitch
// R5 - area 4 field bits 9:7 selects area 4 waits, no burst pitch
// R6 - area 3 field bits 6:5 gives 0..3 waits ordinary memory; wait ignored at 00
// R7 - area 2 field bits 4:3 gives 0..3 waits ordinary memory; wait ignored at 00
// R8 - with synchronous DRAM in area 2 or 3 the field selects CAS latency 1,1,2,3
// R9 - area 0 field bits 2:0 selects first waits and burst pitch
// R10 - area 4 codes give 0,1,2,3,4,6,8,10 waits; wait ignored only at 000
// R11 - area 0 first waits 0..10 and burst pitch 2..10; wait ignored only first cycle 000
// R12 - honoured wait input extends the cycle one state per sampled asserted state
// R13 - every field of the wait control register resets to all ones
package awsc_pkg;

   // register map
   localparam logic [11:0] AWSC_WAIT_CTRL_ADDR = 12'h000;
   localparam int AWSC_REG_W = 16;
   localparam logic [15:0] AWSC_WAIT_CTRL_RST = 16'hFFFF;

   // field layout, lowest bit and width of each area field
   localparam int AWSC_A6_LSB = 13;
   localparam int AWSC_A5_LSB = 10;
   localparam int AWSC_A4_LSB = 7;
   localparam int AWSC_A3_LSB = 5;
   localparam int AWSC_A2_LSB = 3;
   localparam int AWSC_A0_LSB = 0;
   localparam int AWSC_WIDE_W = 3;
   localparam int AWSC_NARROW_W = 2;

   // first-cycle waits per code, code 0 in the lowest nibble
   localparam logic [7:0][3:0] AWSC_FIRST_WAITS =
      {4'hA, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
   // states per burst data transfer per code
   localparam logic [7:0][3:0] AWSC_BURST_PITCH =
      {4'hA, 4'h8, 4'h6, 4'h4, 4'h4, 4'h3, 4'h2, 4'h2};
   // CAS latency per two-bit code
   localparam logic [3:0][1:0] AWSC_CAS_LAT = {2'h3, 2'h2, 2'h1, 2'h1};

   // access sequencer states
   typedef enum logic [1:0] {
      AWSC_IDLE,
      AWSC_FIRST,
      AWSC_BURST
   } awsc_state_t;

endpackage // awsc_pkg

// File: src/awsc_top.sv
// area wait state control: APB register and external access wait sequencer
module awsc_top (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // access request from the bus controller
   input wire logic acc_start_i,
   input wire logic [2:0] acc_area_i,
   input wire logic acc_burst_i,
   input wire logic [1:0] acc_beats_i,
   input wire logic sdram_area2_i,
   input wire logic sdram_area3_i,
   input wire logic mem_wait_b_i,
   output logic acc_ready_o,
   output logic acc_busy_o,
   output logic acc_done_o,
   output logic acc_last_o,
   output logic [1:0] cas_lat_area2_o,
   output logic [1:0] cas_lat_area3_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // register bus decode

   logic [15:0] area_wait_control_r;
   logic [31:0] prdata_r;
   logic addr_hit_w;
   logic setup_w;
   logic access_w;
   logic wr_en_w;
   logic [15:0] byte_mask_w;
   logic [15:0] wait_ctrl_nxt;

   // decode of the only mapped word; everything else answers with an error
   assign addr_hit_w = (paddr_i == awsc_pkg::AWSC_WAIT_CTRL_ADDR);
   assign setup_w = psel_i & ~penable_i;
   assign access_w = psel_i & penable_i;
   assign wr_en_w = access_w & pwrite_i & addr_hit_w;
   assign byte_mask_w = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   assign wait_ctrl_nxt = (area_wait_control_r & ~byte_mask_w)
                        | (pwdata_i[15:0] & byte_mask_w);

   // zero-wait slave, error only for an unmapped word
   assign pready_o = 1'b1;
   assign pslverr_o = access_w & ~addr_hit_w;
   assign prdata_o = prdata_r;

   // wait control register, loaded with all ones at reset
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         area_wait_control_r <= awsc_pkg::AWSC_WAIT_CTRL_RST; // [R13]
      end else if (wr_en_w) begin
         area_wait_control_r <= wait_ctrl_nxt; // [R1]
      end
   end

   // read data captured in the setup phase, upper half reads zero
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_w) begin
         prdata_r <= addr_hit_w ? {16'h0000, area_wait_control_r} : 32'h0000_0000; // [R1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-area timing decode

   logic [7:0][2:0] area_code_w;
   logic [7:0][3:0] area_first_w;
   logic [7:0][3:0] area_pitch_w;
   logic [7:0] area_honour_w;
   logic [7:0] area_burst_ok_w;
   logic [7:0] area_sdram_w;

   // single-bit field wires of the wait control register
   logic area6_wait_sel_hi;
   logic area6_wait_sel_mid;
   logic area6_wait_sel_lo;
   logic area5_wait_sel_hi;
   logic area5_wait_sel_mid;
   logic area5_wait_sel_lo;
   logic area4_wait_sel_hi;
   logic area4_wait_sel_mid;
   logic area4_wait_sel_lo;
   logic area3_wait_sel_hi;
   logic area3_wait_sel_lo;
   logic area2_wait_sel_hi;
   logic area2_wait_sel_lo;
   logic area0_wait_sel_hi;
   logic area0_wait_sel_mid;
   logic area0_wait_sel_lo;

   // field bits picked from their register positions
   assign area6_wait_sel_hi = area_wait_control_r[awsc_pkg::AWSC_A6_LSB + 2]; // [R2]
   assign area6_wait_sel_mid = area_wait_control_r[awsc_pkg::AWSC_A6_LSB + 1]; // [R2]
   assign area6_wait_sel_lo = area_wait_control_r[awsc_pkg::AWSC_A6_LSB]; // [R2]
   assign area5_wait_sel_hi = area_wait_control_r[awsc_pkg::AWSC_A5_LSB + 2]; // [R4]
   assign area5_wait_sel_mid = area_wait_control_r[awsc_pkg::AWSC_A5_LSB + 1]; // [R4]
   assign area5_wait_sel_lo = area_wait_control_r[awsc_pkg::AWSC_A5_LSB]; // [R4]
   assign area4_wait_sel_hi = area_wait_control_r[awsc_pkg::AWSC_A4_LSB + 2]; // [R5]
   assign area4_wait_sel_mid = area_wait_control_r[awsc_pkg::AWSC_A4_LSB + 1]; // [R5]
   assign area4_wait_sel_lo = area_wait_control_r[awsc_pkg::AWSC_A4_LSB]; // [R5]
   assign area3_wait_sel_hi = area_wait_control_r[awsc_pkg::AWSC_A3_LSB + 1]; // [R6]
   assign area3_wait_sel_lo = area_wait_control_r[awsc_pkg::AWSC_A3_LSB]; // [R6]
   assign area2_wait_sel_hi = area_wait_control_r[awsc_pkg::AWSC_A2_LSB + 1]; // [R7]
   assign area2_wait_sel_lo = area_wait_control_r[awsc_pkg::AWSC_A2_LSB]; // [R7]
   assign area0_wait_sel_hi = area_wait_control_r[awsc_pkg::AWSC_A0_LSB + 2]; // [R9]
   assign area0_wait_sel_mid = area_wait_control_r[awsc_pkg::AWSC_A0_LSB + 1]; // [R9]
   assign area0_wait_sel_lo = area_wait_control_r[awsc_pkg::AWSC_A0_LSB]; // [R9]

   // area codes; areas 1 and 7 have no field and run with no waits
   assign area_code_w[0] = {area0_wait_sel_hi, area0_wait_sel_mid, area0_wait_sel_lo}; // [R9]
   assign area_code_w[1] = 3'h0;
   assign area_code_w[2] = {1'b0, area2_wait_sel_hi, area2_wait_sel_lo}; // [R7]
   assign area_code_w[3] = {1'b0, area3_wait_sel_hi, area3_wait_sel_lo}; // [R6]
   assign area_code_w[4] = {area4_wait_sel_hi, area4_wait_sel_mid, area4_wait_sel_lo}; // [R5]
   assign area_code_w[5] = {area5_wait_sel_hi, area5_wait_sel_mid, area5_wait_sel_lo}; // [R4]
   assign area_code_w[6] = {area6_wait_sel_hi, area6_wait_sel_mid, area6_wait_sel_lo}; // [R2]
   assign area_code_w[7] = 3'h0;

   // synchronous DRAM only possible in areas 2 and 3
   assign area_sdram_w = {4'h0, sdram_area3_i, sdram_area2_i, 2'h0};

   // one decode per area: waits, pitch, wait-pin honour and burst capability
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_area
         logic [1:0] cas_w;
         assign cas_w = awsc_pkg::AWSC_CAS_LAT[area_code_w[g][1:0]];
         // code 0 ignores the wait pin in the first cycle
         assign area_honour_w[g] = (area_code_w[g] != 3'h0) & ~area_sdram_w[g]; // [R2] [R10]
         // CAS latency replaces the wait count on synchronous DRAM
         assign area_first_w[g] = area_sdram_w[g] ? {2'h0, cas_w} // [R8]
                                : awsc_pkg::AWSC_FIRST_WAITS[area_code_w[g]]; // [R10] [R11]
         assign area_pitch_w[g] = awsc_pkg::AWSC_BURST_PITCH[area_code_w[g]]; // [R3] [R11]
         assign area_burst_ok_w[g] = (g == 0) || (g == 5) || (g == 6); // [R4] [R5] [R9]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // CAS latency outputs

   logic [1:0] cas2_r;
   logic [1:0] cas3_r;

   // latency of areas 2 and 3, valid while synchronous DRAM is attached
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cas2_r <= 2'h0;
         cas3_r <= 2'h0;
      end else begin
         cas2_r <= awsc_pkg::AWSC_CAS_LAT[area_code_w[2][1:0]]; // [R8]
         cas3_r <= awsc_pkg::AWSC_CAS_LAT[area_code_w[3][1:0]]; // [R8]
      end
   end

   assign cas_lat_area2_o = cas2_r;
   assign cas_lat_area3_o = cas3_r;

   ////////////////////////////////////////////////////////////////////////////////
   // access sequencer
   //
   // timing of one access, counted in clock edges:
   // - the start edge loads the first-cycle count of the area
   // - each following edge takes one off the count
   // - once the count is zero, an edge with no honoured wait completes the transfer
   // - an honoured wait seen at a zero count keeps the transfer one more state
   // - the first transfer thus spans the programmed waits plus one state
   // - a burst beat reloads the pitch minus one, so it spans the pitch
   // - burst beats honour the wait pin whatever the code
   // - the first cycle honours it only for a non-zero code
   // - synchronous DRAM areas use the CAS latency as count, wait pin ignored
   // - done and last rise on the completing edge itself and pulse for one cycle
   // - ready returns on the same edge, so a new start comes one cycle later
   //
   // hazards kept in mind:
   // - the area timing is latched at the start edge
   // - a register write during an access only affects the next one
   // - areas without a burst pitch run a burst request as a single
   // - the wait pin is sampled only at a zero count, so an early
   //   wait from slow memory costs nothing while waits still run
   // - a wait held low forever hangs the access; the bus controller
   //   above is expected to bound it
   //
   // limitations:
   // - no idle cycles are inserted between accesses here
   // - refresh and synchronous DRAM commands are handled elsewhere
   // - areas 1 and 7 are treated as zero-wait memory

   awsc_pkg::awsc_state_t state_r;
   awsc_pkg::awsc_state_t state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [1:0] beats_r;
   logic [1:0] beats_nxt;
   logic [3:0] pitch_r;
   logic honour_r;
   logic burst_r;
   logic done_r;
   logic last_r;
   logic start_w;
   logic wait_hold_w;
   logic xfer_end_w;
   logic more_w;

   assign start_w = (state_r == awsc_pkg::AWSC_IDLE) & acc_start_i;
   // burst beats honour the wait pin for every code, first cycle per its code
   assign wait_hold_w = ~mem_wait_b_i
                      & ((state_r == awsc_pkg::AWSC_BURST) | honour_r); // [R3] [R12]
   // a transfer ends once its count runs out and no honoured wait is seen
   assign xfer_end_w = (state_r != awsc_pkg::AWSC_IDLE) & (cnt_r == 4'h0)
                     & ~wait_hold_w; // [R12]
   assign more_w = burst_r & (beats_r != 2'h0);

   assign acc_ready_o = (state_r == awsc_pkg::AWSC_IDLE);
   assign acc_busy_o = (state_r != awsc_pkg::AWSC_IDLE);
   assign acc_done_o = done_r;
   assign acc_last_o = last_r;

   // next state, count and remaining beats
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      beats_nxt = beats_r;
      unique case (state_r)
         awsc_pkg::AWSC_IDLE: begin
            if (acc_start_i) begin
               state_nxt = awsc_pkg::AWSC_FIRST;
               cnt_nxt = area_first_w[acc_area_i];
               beats_nxt = acc_beats_i;
            end
         end
         awsc_pkg::AWSC_FIRST, awsc_pkg::AWSC_BURST: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (xfer_end_w) begin
               if (more_w) begin
                  state_nxt = awsc_pkg::AWSC_BURST;
                  cnt_nxt = pitch_r - 4'h1; // [R3]
                  beats_nxt = beats_r - 2'h1;
               end else begin
                  state_nxt = awsc_pkg::AWSC_IDLE;
               end
            end
            // otherwise stay one more state for the asserted wait [R12]
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= awsc_pkg::AWSC_IDLE;
         cnt_r <= 4'h0;
         beats_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         beats_r <= beats_nxt;
      end
   end

   // timing of the access latched at its start, so a register write mid-access is harmless
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pitch_r <= 4'h2;
         honour_r <= 1'b0;
         burst_r <= 1'b0;
      end else if (start_w) begin
         pitch_r <= area_pitch_w[acc_area_i];
         honour_r <= area_honour_w[acc_area_i];
         burst_r <= acc_burst_i & area_burst_ok_w[acc_area_i];
      end
   end

   // end-of-transfer strobes
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         done_r <= xfer_end_w;
         last_r <= xfer_end_w & ~more_w;
      end
   end

endmodule // awsc_top

// File: tb/awsc_chk.sv
// checker: port properties of the wait state control block
module awsc_chk (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic acc_start_i,
   input wire logic acc_ready_o,
   input wire logic acc_busy_o,
   input wire logic acc_done_o,
   input wire logic acc_last_o,
   input wire logic [1:0] cas_lat_area2_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic wr_low;
   wire logic xfer;
   //////////////////////////////
   // qualified low byte write and accepted access start
   assign wr_low = psel_i && penable_i && pwrite_i && paddr_i == 12'h000 && pstrb_i[0];
   assign xfer = acc_start_i && acc_ready_o;
   a_upper_zero: assert property (prdata_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_unmapped_err: assert property (psel_i && penable_i && paddr_i != 12'h000 |-> pslverr_o)
      else $error("unmapped access without error");
   a_reset_slow: assert property ($rose(rst_b_i) |=> cas_lat_area2_o == 2'h3)
      else $error("latency not slowest after reset");
   a_cas_follow: assert property (wr_low |=> ##1 cas_lat_area2_o ==
      (($past(pwdata_i[4:3], 2) == 2'h0) ? 2'h1 : $past(pwdata_i[4:3], 2)))
      else $error("latency output does not follow field");
   a_done_pulse: assert property (acc_done_o |=> !acc_done_o)
      else $error("done longer than one cycle");
   a_last_done: assert property (acc_last_o |-> acc_done_o)
      else $error("last without done");
   a_busy_end: assert property ($fell(acc_busy_o) |-> acc_done_o && acc_last_o)
      else $error("busy ended without final done");
   a_start_done: assert property (xfer |=> acc_busy_o ##[1:40] acc_done_o)
      else $error("access did not complete in time");
endmodule // awsc_chk
bind awsc_top awsc_chk awsc_chk_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .acc_start_i(acc_start_i), .acc_ready_o(acc_ready_o), .acc_busy_o(acc_busy_o),
   .acc_done_o(acc_done_o), .acc_last_o(acc_last_o), .cas_lat_area2_o(cas_lat_area2_o));

// File: tb/awsc_mem_model.sv
// external memory model: holds wait low for the first stall_i busy states
module awsc_mem_model (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic acc_busy_i,
   input wire logic [3:0] stall_i,
   output logic mem_wait_b_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_r;
   // count busy states, cleared while idle
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) cnt_r <= 4'h0;
      else if (!acc_busy_i) cnt_r <= 4'h0;
      else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
   end
   // wait line idles high, low while stalling
   assign mem_wait_b_o = !(acc_busy_i && cnt_r < stall_i);
endmodule // awsc_mem_model

// File: tb/area_wait_state_control_tb_top.sv
// testbench: register access and wait timing of every area
module area_wait_state_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic acc_start_i = 1'b0;
   logic acc_burst_i = 1'b0;
   logic sdram_area2_i = 1'b0;
   logic sdram_area3_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0] pstrb_i = 4'hF;
   logic [3:0] stall = 4'h0;
   logic [2:0] acc_area_i = 3'h0;
   logic [1:0] acc_beats_i = 2'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, mem_wait_b_i, acc_ready_o, acc_busy_o, acc_done_o, acc_last_o;
   logic [1:0] cas_lat_area2_o, cas_lat_area3_o;
   logic [15:0] reg_m;
   logic [31:0] rd, r;
   logic err;
   int fails = 0, total_checks = 0, seed = 32'ha021, i;
   always #5 sys_clk_i = ~sys_clk_i;
   awsc_top awsc_top_inst (.sys_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .acc_start_i, .acc_area_i,
      .acc_burst_i, .acc_beats_i, .sdram_area2_i, .sdram_area3_i, .mem_wait_b_i,
      .acc_ready_o, .acc_busy_o, .acc_done_o, .acc_last_o, .cas_lat_area2_o, .cas_lat_area3_o);
   awsc_mem_model awsc_mem_model_inst (.sys_clk_i, .rst_b_i, .acc_busy_i(acc_busy_o),
      .stall_i(stall), .mem_wait_b_o(mem_wait_b_i));
   //////////////////////////////
   // comparison, verdict and expected timing
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function int cyc(input logic [2:0] a, input int st, input logic bst, input int e);
      int t[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
      int p[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
      logic [2:0] cd;
      int w, base;
      logic h;
      case (a)
         3'd0: cd = reg_m[2:0];
         3'd2: cd = {1'b0, reg_m[4:3]};
         3'd3: cd = {1'b0, reg_m[6:5]};
         3'd4: cd = reg_m[9:7];
         3'd5: cd = reg_m[12:10];
         3'd6: cd = reg_m[15:13];
         default: cd = 3'h0;
      endcase
      w = t[cd];
      h = (cd != 3'h0);
      if ((a == 3'd2 && sdram_area2_i) || (a == 3'd3 && sdram_area3_i)) begin
         w = (cd == 3'h0) ? 1 : int'(cd);
         h = 1'b0;
      end
      base = w + 1;
      if (bst) begin
         base = p[cd];
         h = 1'b1;
      end
      // wait is sampled at the last state of a transfer, e busy edges in
      return base + ((h && st > e + base - 1) ? st - (e + base - 1) : 0);
   endfunction
   // one APB transfer, register model follows accepted writes
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (w && a == 12'h000 && s[0]) reg_m[7:0] = d[7:0];
      if (w && a == 12'h000 && s[1]) reg_m[15:8] = d[15:8];
   endtask
   // one access, first transfer timed from the start edge, each later one from the previous done
   task acc(input logic [2:0] a, input logic b, input logic [1:0] n, input logic [3:0] st);
      int c, k, nb, e;
      nb = (b && (a == 3'd0 || a == 3'd5 || a == 3'd6)) ? int'(n) : 0;
      e = 0;
      @(posedge sys_clk_i);
      acc_start_i <= 1'b1;
      acc_area_i <= a;
      acc_burst_i <= b;
      acc_beats_i <= n;
      stall <= st;
      @(posedge sys_clk_i);
      acc_start_i <= 1'b0;
      for (k = 0; k <= nb; k++) begin
         c = 0;
         do begin
            @(posedge sys_clk_i);
            #1;
            c++;
         end while (acc_done_o !== 1'b1 && c < 100);
         check("cycles", c, cyc(a, st, k > 0, e));
         check("last", acc_last_o, k == nb);
         e = e + c;
      end
   endtask
   task do_reset;
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      reg_m = 16'hFFFF;
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      check("reset value", rd, 32'h0000FFFF);
      check("cas reset", cas_lat_area3_o, 2'h3);
   endtask
   // main sequence: corners, random traffic, ignored waits, second reset
   initial begin
      do_reset();
      acc(3'd6, 1'b1, 2'h3, 4'h0);
      apb(1'b1, 12'h004, 32'h0000_1234, 4'hF);
      check("unmapped err", err, 1'b1);
      apb(1'b1, 12'h000, 32'hFFFF_0000, 4'h1);
      apb(1'b0, 12'h004, 32'h0, 4'hF);
      check("unmapped read", rd, 32'h0);
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      check("strobe write", rd, {16'h0, reg_m});
      for (i = 0; i < 40; i++) begin
         r = $random(seed);
         apb(1'b1, 12'h000, r, 4'hF);
         apb(1'b0, 12'h000, 32'h0, 4'hF);
         check("readback", rd, {16'h0, reg_m});
         check("cas area2", cas_lat_area2_o, (r[4:3] == 2'h0) ? 2'h1 : r[4:3]);
         sdram_area2_i <= r[17];
         sdram_area3_i <= r[18];
         acc(r[22:20], r[23], r[25:24], {1'b0, r[28:26]});
      end
      sdram_area2_i <= 1'b0;
      sdram_area3_i <= 1'b0;
      apb(1'b1, 12'h000, 32'h0, 4'hF);
      for (i = 0; i < 7; i++) acc(i[2:0], 1'b1, 2'h1, 4'h5);
      do_reset();
      end_sim();
   end
   // watchdog against a hung handshake
   initial begin
      #200000;
      fails++;
      end_sim();
   end
endmodule // area_wait_state_control_tb_top
